// ---- rtl/switch_port_capability_space.sv ----
// Per-port capability register bank of a packet switch port
`timescale 1ns/1ps
`default_nettype none

// Operation
// R01 - Two-bit RW power state D0..D3hot, resets to D0
// R02 - Writing D0 from D3hot fires hot reset, downstream reset stays off
// R03 - RO skip-internal-reset bit, resets 1, loadable default
// R04 - RW power-event enable, resets 0, gates event message generation
// R05 - Power-event status reads 0; data scale RO 00b
// R06 - PM header ID 01h; next 5Ch upstream, 4Ch downstream
// R07 - PM caps: rev 011b, aux 111b, D1/D2 1, events 11111b, init 0
// R08 - Loadable RO fields take loaded value when provided, else reset value
// R09 - Four-bit RW data select, eight-bit RO loadable data field
// R10 - Bridge B2/B3, bus power control, event clock bits read 0
// R11 - Downstream only: message-interrupt capability ID 05h, next 64h
// R12 - Enable set: message writes, no legacy INTx; clear: no message writes
// R13 - Multi-message capable 000b, enable RW 000b, 64-bit capable 1
// R14 - Message lower address dword aligned, upper 32-bit, data 16-bit, RW
// R15 - Upstream only: product-data capability ID 03h, next 64h
// R16 - Six-bit DWORD address selects EEPROM table location
// R17 - Write 0 to op flag starts read; flag set to 1 when done
// R18 - With write enable, op flag 1 starts write; cleared when done
// R19 - Data word reads last fetched value; writes supply stored data
// R20 - Vendor capability ID 09h, next B0h, length 34h
// R21 - Test word zero resets 0400_1060h; bit1 role change, bit3 role
// R22 - Upstream: bit2 set suppresses downstream hot reset on link down
// R23 - Reserved bits read zero; test word one plain RW
module switch_port_capability_space
    import port_cap_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b1
) (
    input wire logic clk_sys, // Core clock, 25 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire port_cap_pkg::cfg_req_t cfgReq, // Configuration request
    output logic [31:0] cfgRdata, // Read data, one cycle after rd
    output logic cfgRvalid, // Read data valid pulse
    input wire logic loadValid, // Autoload of loadable defaults
    input wire port_cap_pkg::load_defaults_t loadData, // Loaded values
    output port_cap_pkg::pd_req_t pdReq, // EEPROM table request
    input wire logic pdDone, // EEPROM cycle finished pulse
    input wire logic [31:0] pdRdata, // Fetched word, valid with pdDone
    input wire logic serviceReq, // Port needs interrupt service
    output logic msgWriteReq, // Message write request pulse
    output logic [63:0] msgAddr, // Message write address
    output logic [15:0] msgData, // Message write data
    output logic legacyIntx, // Legacy interrupt level
    output logic powerEventMsg, // Power event message pulse
    input wire logic powerEventReq, // Internal wake event
    output logic hotReset, // Internal hot reset pulse
    input wire logic upLinkDown, // Upstream link down level
    output logic downstreamHotReset, // Hot reset to downstream ports
    output logic downstreamRoleSelect, // Link role: 1 downstream
    output logic roleChangeEnable, // Role change allowed
    output logic downstream_reset_n // Downstream reset, active low
);
    import port_cap_pkg::*;

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    power_state_t powerState;
    logic evtEnable;
    logic [3:0] dataSelect;
    load_defaults_t ldf;
    logic miEnable;
    logic [2:0] miMultiEnable;
    logic [29:0] miAddrLow;
    logic [31:0] miAddrHigh;
    logic [15:0] miData;
    logic [5:0] pdAddr;
    logic pdWriteEnable;
    logic pdOp;
    logic pdBusy;
    logic [31:0] pdWord;
    logic [31:0] testCtl0;
    logic [31:0] testCtl1;
    logic linkDownSync1;
    logic linkDownSync2;
    logic linkDownPrev;
    logic svcPrev;
    logic evtPrev;

    logic wrHit;
    logic [31:0] wMask;
    logic [31:0] wd;
    assign wrHit = cfgReq.wr;
    assign wd = cfgReq.wdata;
    assign wMask = {{8{cfgReq.be[3]}}, {8{cfgReq.be[2]}},
                    {8{cfgReq.be[1]}}, {8{cfgReq.be[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (old & ~wMask) | (wd & wMask);
    endfunction : merge

    // ---------------------------------------------------------------
    // Loadable defaults
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ldf.skipReset <= 1'b1;
            ldf.devInit <= 1'b0;
            ldf.auxCurrent <= PM_AUX_RST;
            ldf.d1Support <= 1'b1;
            ldf.d2Support <= 1'b1;
            ldf.eventSupport <= PM_EVT_SUP_RST;
            ldf.dataValue <= 8'h00;
        end else if (loadValid) begin
            ldf <= loadData; // R08 R03 R09
        end
    end

    // ---------------------------------------------------------------
    // Power management control
    // ---------------------------------------------------------------
    logic pmWr;
    logic [31:0] pmNew;
    assign pmWr = wrHit && cfgReq.addr == OFF_PM_CTL;
    assign pmNew = merge({16'h0000, 3'h0, dataSelect, evtEnable, 6'h00,
                          powerState});

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            powerState <= PS_D0;
            evtEnable <= 1'b0;
            dataSelect <= 4'h0;
            hotReset <= 1'b0;
        end else begin
            hotReset <= 1'b0;
            if (pmWr) begin
                powerState <= power_state_t'(pmNew[1:0]); // R01
                evtEnable <= pmNew[PM_EVT_EN_BIT]; // R04
                dataSelect <= pmNew[12:9]; // R09
                // Hot reset only; downstream reset pin untouched
                if (powerState == PS_D3HOT && pmNew[1:0] == PS_D0 &&
                    cfgReq.be[0]) begin
                    hotReset <= 1'b1; // R02
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            powerEventMsg <= 1'b0;
            evtPrev <= 1'b0;
        end else begin
            evtPrev <= powerEventReq;
            powerEventMsg <= evtEnable && powerEventReq && !evtPrev; // R04
        end
    end

    // ---------------------------------------------------------------
    // Message interrupt (downstream only)
    // ---------------------------------------------------------------
    logic miWr;
    logic [31:0] miCtlNew;
    logic [31:0] miAdlNew;
    logic [31:0] miDatNew;
    assign miWr = wrHit && !IS_UPSTREAM;
    assign miCtlNew = merge({8'h00, 1'b1, miMultiEnable, 3'h0, miEnable,
                             16'h0000});
    assign miAdlNew = merge({miAddrLow, 2'b00});
    assign miDatNew = merge({16'h0000, miData});

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            miEnable <= 1'b0;
            miMultiEnable <= 3'h0;
            miAddrLow <= 30'h0000_0000;
            miAddrHigh <= 32'h0000_0000;
            miData <= 16'h0000;
        end else if (miWr) begin
            unique case (cfgReq.addr)
                OFF_MI_HDR: begin
                    miEnable <= miCtlNew[MI_EN_BIT]; // R12
                    miMultiEnable <= miCtlNew[22:20]; // R13
                end
                OFF_MI_ADL: miAddrLow <= miAdlNew[31:2]; // R14
                OFF_MI_ADH: miAddrHigh <= merge(miAddrHigh); // R14
                OFF_MI_DAT: miData <= miDatNew[15:0]; // R14
                default: ;
            endcase
        end
    end

    // Service request edges become message writes or legacy level
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            svcPrev <= 1'b0;
            msgWriteReq <= 1'b0;
            msgAddr <= 64'h0000_0000_0000_0000;
            msgData <= 16'h0000;
            legacyIntx <= 1'b0;
        end else begin
            svcPrev <= serviceReq;
            msgWriteReq <= !IS_UPSTREAM && miEnable &&
                           serviceReq && !svcPrev; // R12
            msgAddr <= {miAddrHigh, miAddrLow, 2'b00}; // R14
            msgData <= miData;
            legacyIntx <= serviceReq && !miEnable; // R12
        end
    end

    // ---------------------------------------------------------------
    // Product data (upstream only)
    // ---------------------------------------------------------------
    logic pdCtlWr;
    logic pdWrdWr;
    logic [31:0] pdCtlNew;
    assign pdCtlWr = wrHit && IS_UPSTREAM && cfgReq.addr == OFF_PD_CTL;
    assign pdWrdWr = wrHit && IS_UPSTREAM && cfgReq.addr == OFF_PD_WRD;
    assign pdCtlNew = merge({pdOp, pdWriteEnable, 6'h00, pdAddr, 18'h00000});

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pdAddr <= 6'h00;
            pdWriteEnable <= 1'b0;
            pdOp <= 1'b0;
            pdBusy <= 1'b0;
            pdReq <= '0;
        end else begin
            pdReq.start <= 1'b0;
            if (pdBusy && pdDone) begin
                pdBusy <= 1'b0;
                pdOp <= !pdOp; // R17 R18
            end else if (pdCtlWr && !pdBusy && cfgReq.be[3]) begin
                // Writes landing mid-cycle are ignored to keep the flag
                pdAddr <= pdCtlNew[23:18]; // R16
                pdWriteEnable <= pdCtlNew[PD_WE_BIT];
                if (!pdCtlNew[PD_OP_BIT] ||
                    pdCtlNew[PD_WE_BIT]) begin
                    pdOp <= pdCtlNew[PD_OP_BIT]; // R17 R18
                    pdBusy <= 1'b1;
                    pdReq.start <= 1'b1;
                    pdReq.write <= pdCtlNew[PD_OP_BIT];
                    pdReq.addr <= pdCtlNew[23:18]; // R16
                    pdReq.data <= pdWord; // R19
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pdWord <= 32'h0000_0000;
        end else if (pdBusy && pdDone && !pdOp) begin
            pdWord <= pdRdata; // R19
        end else if (pdWrdWr) begin
            pdWord <= merge(pdWord); // R19
        end
    end

    // ---------------------------------------------------------------
    // Test control words and link-down hot reset
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            testCtl0 <= TST0_RST;
            testCtl1 <= TST1_RST;
        end else if (wrHit) begin
            if (cfgReq.addr == OFF_TST0) testCtl0 <= merge(testCtl0); // R21
            if (cfgReq.addr == OFF_TST1) testCtl1 <= merge(testCtl1); // R23
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            linkDownSync1 <= 1'b0;
            linkDownSync2 <= 1'b0;
            linkDownPrev <= 1'b0;
            downstreamHotReset <= 1'b0;
            downstreamRoleSelect <= 1'b0;
            roleChangeEnable <= 1'b0;
            downstream_reset_n <= 1'b1;
        end else begin
            linkDownSync1 <= upLinkDown;
            linkDownSync2 <= linkDownSync1;
            linkDownPrev <= linkDownSync2;
            downstreamHotReset <= IS_UPSTREAM && linkDownSync2 &&
                !linkDownPrev && !testCtl0[TST0_NO_HRST_BIT]; // R22
            downstreamRoleSelect <= testCtl0[TST0_DN_ROLE_BIT]; // R21
            roleChangeEnable <= testCtl0[TST0_ROLE_EN_BIT]; // R21
            downstream_reset_n <= 1'b1; // R02
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000; // R23
        unique case (cfgReq.addr)
            OFF_PM_HDR: rdMux = {ldf.eventSupport, ldf.d2Support,
                ldf.d1Support, ldf.auxCurrent, ldf.devInit, 1'b0, 1'b0,
                PM_REVISION, IS_UPSTREAM ? PM_NEXT_UP : PM_NEXT_DN,
                PM_CAP_ID}; // R06 R07 R10
            OFF_PM_CTL: rdMux = {ldf.dataValue, 2'b00, 6'h00, 1'b0, 2'b00,
                dataSelect, evtEnable, 4'h0, ldf.skipReset, 1'b0,
                powerState}; // R05 R09 R10 R03
            OFF_MI_HDR: if (!IS_UPSTREAM) rdMux = {8'h00, 1'b1,
                miMultiEnable, 3'h0, miEnable, CAP_NEXT_VS,
                MI_CAP_ID}; // R11 R13
            OFF_MI_ADL: if (!IS_UPSTREAM) rdMux = {miAddrLow, 2'b00};
            OFF_MI_ADH: if (!IS_UPSTREAM) rdMux = miAddrHigh;
            OFF_MI_DAT: if (!IS_UPSTREAM) rdMux = {16'h0000, miData};
            OFF_PD_CTL: if (IS_UPSTREAM) rdMux = {pdOp, pdWriteEnable,
                6'h00, pdAddr, 2'b00, CAP_NEXT_VS, PD_CAP_ID}; // R15
            OFF_PD_WRD: if (IS_UPSTREAM) rdMux = pdWord; // R19
            OFF_VS_HDR: rdMux = {VS_LENGTH, VS_NEXT, VS_CAP_ID}; // R20
            OFF_TST0: rdMux = testCtl0;
            OFF_TST1: rdMux = testCtl1;
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfgRdata <= 32'h0000_0000;
            cfgRvalid <= 1'b0;
        end else begin
            cfgRvalid <= cfgReq.rd;
            cfgRdata <= cfgReq.rd ? rdMux : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    property p_pm_reset_d0;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(hotReset) |-> $past(powerState) == PS_D3HOT &&
            powerState == PS_D0;
    endproperty
    a_pm_reset_d0: assert property (p_pm_reset_d0) else $error("hot reset without D3hot to D0"); // R02

    property p_no_dn_reset;
        @(posedge clk_sys) disable iff (sys_rst) downstream_reset_n;
    endproperty
    a_no_dn_reset: assert property (p_no_dn_reset) else $error("downstream reset driven"); // R02

    property p_evt_gate;
        @(posedge clk_sys) disable iff (sys_rst)
        powerEventMsg |-> $past(evtEnable);
    endproperty
    a_evt_gate: assert property (p_evt_gate) else $error("event message while disabled"); // R04

    property p_msg_gate;
        @(posedge clk_sys) disable iff (sys_rst)
        msgWriteReq |-> $past(miEnable) && !legacyIntx;
    endproperty
    a_msg_gate: assert property (p_msg_gate) else $error("message write while disabled"); // R12

    sequence s_pd_start_read;
        pdReq.start && !pdReq.write;
    endsequence
    property p_pd_read_flag;
        @(posedge clk_sys) disable iff (sys_rst)
        s_pd_start_read |-> !pdOp throughout (pdBusy [*1]);
    endproperty
    a_pd_read_flag: assert property (p_pd_read_flag) else $error("read flag not held 0"); // R17

    property p_pd_done_flip;
        @(posedge clk_sys) disable iff (sys_rst)
        pdBusy && pdDone |=> !pdBusy && pdOp != $past(pdOp);
    endproperty
    a_pd_done_flip: assert property (p_pd_done_flip) else $error("flag not toggled on done"); // R18

    property p_rd_latency;
        @(posedge clk_sys) disable iff (sys_rst)
        cfgReq.rd && cfgReq.addr == OFF_VS_HDR |=>
            cfgRvalid && cfgRdata == 32'h0034_B009;
    endproperty
    a_rd_latency: assert property (p_rd_latency) else $error("vendor header wrong"); // R20

    property p_hrst_suppress;
        @(posedge clk_sys) disable iff (sys_rst)
        downstreamHotReset |-> !$past(testCtl0[TST0_NO_HRST_BIT]);
    endproperty
    a_hrst_suppress: assert property (p_hrst_suppress) else $error("hot reset despite disable"); // R22
endmodule : switch_port_capability_space
`default_nettype wire

// ---- rtl/port_cap_pkg.sv ----
// Constants and types for the switch port capability register bank
package port_cap_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_PM_HDR = 8'h40;
    localparam logic [7:0] OFF_PM_CTL = 8'h44;
    localparam logic [7:0] OFF_MI_HDR = 8'h4C;
    localparam logic [7:0] OFF_MI_ADL = 8'h50;
    localparam logic [7:0] OFF_MI_ADH = 8'h54;
    localparam logic [7:0] OFF_MI_DAT = 8'h58;
    localparam logic [7:0] OFF_PD_CTL = 8'h5C;
    localparam logic [7:0] OFF_PD_WRD = 8'h60;
    localparam logic [7:0] OFF_VS_HDR = 8'h64;
    localparam logic [7:0] OFF_TST0 = 8'h68;
    localparam logic [7:0] OFF_TST1 = 8'h6C;
    // ---------------------------------------------------------------
    // Fixed field values and reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] PM_CAP_ID = 8'h01;
    localparam logic [7:0] PM_NEXT_UP = 8'h5C;
    localparam logic [7:0] PM_NEXT_DN = 8'h4C;
    localparam logic [2:0] PM_REVISION = 3'h3;
    localparam logic [2:0] PM_AUX_RST = 3'h7;
    localparam logic [4:0] PM_EVT_SUP_RST = 5'h1F;
    localparam logic [7:0] MI_CAP_ID = 8'h05;
    localparam logic [7:0] PD_CAP_ID = 8'h03;
    localparam logic [7:0] CAP_NEXT_VS = 8'h64;
    localparam logic [7:0] VS_CAP_ID = 8'h09;
    localparam logic [7:0] VS_NEXT = 8'hB0;
    localparam logic [15:0] VS_LENGTH = 16'h0034;
    localparam logic [31:0] TST0_RST = 32'h0400_1060;
    localparam logic [31:0] TST1_RST = 32'h0400_0800;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int TST0_ROLE_EN_BIT = 1;
    localparam int TST0_NO_HRST_BIT = 2;
    localparam int TST0_DN_ROLE_BIT = 3;
    localparam int PD_OP_BIT = 31;
    localparam int PD_WE_BIT = 30;
    localparam int MI_EN_BIT = 16;
    localparam int PM_EVT_EN_BIT = 8;

    typedef enum logic [1:0] {
        PS_D0 = 2'b00,
        PS_D1 = 2'b01,
        PS_D2 = 2'b10,
        PS_D3HOT = 2'b11
    } power_state_t;

    // Loadable read-only defaults (SMBus, I2C or EEPROM autoload)
    typedef struct packed {
        logic skipReset;
        logic devInit;
        logic [2:0] auxCurrent;
        logic d1Support;
        logic d2Support;
        logic [4:0] eventSupport;
        logic [7:0] dataValue;
    } load_defaults_t;

    // Configuration request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    // Product-data table access toward the EEPROM controller
    typedef struct packed {
        logic start;
        logic write;
        logic [5:0] addr;
        logic [31:0] data;
    } pd_req_t;
endpackage : port_cap_pkg

// ---- verification/product_data_eeprom.sv ----
// Behavioural serial table memory answering product-data cycles
`timescale 1ns/1ps
`default_nettype none
module product_data_eeprom
    import port_cap_pkg::*;
#(
    parameter int LATENCY = 7 // Cycles from start to done
) (
    input wire logic clk_sys, // Core clock
    input wire port_cap_pkg::pd_req_t pdReq, // Table request
    output logic pdDone, // Cycle finished pulse
    output logic [31:0] pdRdata // Fetched word, valid with pdDone
);
    logic [31:0] mem [64];
    int busy = 0;
    initial pdDone = 1'b0;
    initial pdRdata = 32'h0;
    // Data line toggles outside done so a stale read cannot pass
    always @(posedge clk_sys) begin
        pdDone <= (busy == 1);
        if (busy == 1 && !pdReq.write)
            pdRdata <= mem[pdReq.addr];
        else
            pdRdata <= ~pdRdata;
        if (busy == 1 && pdReq.write)
            mem[pdReq.addr] <= pdReq.data;
        if (busy > 0)
            busy <= busy - 1;
        else if (pdReq.start)
            busy <= LATENCY;
    end
endmodule : product_data_eeprom
`default_nettype wire

// ---- verification/switch_port_capability_space_tb.sv ----
// Self-checking bench for the port capability register bank
`timescale 1ns/1ps
`default_nettype none
module switch_port_capability_space_tb;
    import port_cap_pkg::*;
    localparam logic [15:0] PM_HI = {PM_EVT_SUP_RST, 2'b11, PM_AUX_RST,
        3'b000, PM_REVISION};
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    cfg_req_t cfgReq = '0;
    load_defaults_t loadData = '0;
    logic loadValid = 1'b0;
    logic serviceReq = 1'b0;
    logic powerEventReq = 1'b0;
    logic upLinkDown = 1'b0;
    logic [31:0] upData, dnData, pdRdata;
    logic upValid, pdDone, hotReset, powerEventMsg, downstreamHotReset;
    logic downstreamRoleSelect, roleChangeEnable, downstream_reset_n;
    logic msgWriteReq, legacyIntx;
    logic [63:0] msgAddr;
    logic [15:0] msgData;
    pd_req_t pdReq;
    int fails = 0, checks_done = 0, cycles = 0;
    int hotCount = 0, eventCount = 0, downCount = 0, msgCount = 0;

    switch_port_capability_space #(.IS_UPSTREAM(1'b1)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cfgReq(cfgReq),
        .cfgRdata(upData), .cfgRvalid(upValid), .loadValid(loadValid),
        .loadData(loadData), .pdReq(pdReq), .pdDone(pdDone),
        .pdRdata(pdRdata), .serviceReq(serviceReq), .msgWriteReq(),
        .msgAddr(), .msgData(), .legacyIntx(),
        .powerEventMsg(powerEventMsg), .powerEventReq(powerEventReq),
        .hotReset(hotReset), .upLinkDown(upLinkDown),
        .downstreamHotReset(downstreamHotReset),
        .downstreamRoleSelect(downstreamRoleSelect),
        .roleChangeEnable(roleChangeEnable),
        .downstream_reset_n(downstream_reset_n));
    switch_port_capability_space #(.IS_UPSTREAM(1'b0)) dutDn (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cfgReq(cfgReq),
        .cfgRdata(dnData), .cfgRvalid(), .loadValid(loadValid),
        .loadData(loadData), .pdReq(), .pdDone(1'b0), .pdRdata(32'h0),
        .serviceReq(serviceReq), .msgWriteReq(msgWriteReq),
        .msgAddr(msgAddr), .msgData(msgData), .legacyIntx(legacyIntx),
        .powerEventMsg(), .powerEventReq(powerEventReq), .hotReset(),
        .upLinkDown(upLinkDown), .downstreamHotReset(),
        .downstreamRoleSelect(), .roleChangeEnable(),
        .downstream_reset_n());
    product_data_eeprom table0 (.clk_sys(clk_sys), .pdReq(pdReq),
        .pdDone(pdDone), .pdRdata(pdRdata));

    always #20 clk_sys = ~clk_sys;
    // Pulse counters; a hang is cut off by the cycle ceiling
    always @(posedge clk_sys) begin
        cycles++;
        hotCount += hotReset;
        eventCount += powerEventMsg;
        downCount += downstreamHotReset;
        msgCount += msgWriteReq;
        if (cycles > 5000) begin
            fails++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic cfg_write(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be = 4'hF);
        @(posedge clk_sys);
        cfgReq <= '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
        @(posedge clk_sys);
        cfgReq.wr <= 1'b0;
    endtask : cfg_write

    task automatic cfg_read(input logic [7:0] a, output logic [31:0] u,
        output logic [31:0] d);
        @(posedge clk_sys);
        cfgReq <= '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'hF, wdata: 32'h0};
        @(posedge clk_sys);
        cfgReq.rd <= 1'b0;
        @(negedge clk_sys);
        check({31'h0, upValid}, 32'h1);
        u = upData;
        d = dnData;
    endtask : cfg_read

    task automatic expect_rd(input logic [7:0] a, input logic [31:0] eu,
        input logic [31:0] ed);
        logic [31:0] u, d;
        cfg_read(a, u, d);
        check(u, eu);
        check(d, ed);
    endtask : expect_rd

    // Polls the operation flag; the table part is slow
    task automatic wait_op(input logic v);
        logic [31:0] u, d;
        int n;
        n = 0;
        do begin
            cfg_read(OFF_PD_CTL, u, d);
            n++;
        end while (u[31] !== v && n < 20);
        check({31'h0, u[31]}, {31'h0, v});
    endtask : wait_op

    task automatic stir(input int s, input logic v);
        @(posedge clk_sys);
        case (s)
            0: serviceReq <= v;
            1: powerEventReq <= v;
            default: upLinkDown <= v;
        endcase
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : stir

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    initial begin
        logic [31:0] u, d;
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        expect_rd(OFF_PM_HDR, {PM_HI, PM_NEXT_UP, PM_CAP_ID},
            {PM_HI, PM_NEXT_DN, PM_CAP_ID});
        expect_rd(OFF_PM_CTL, 32'h8, 32'h8);
        expect_rd(OFF_MI_HDR, 32'h0, 32'h0080_6405);
        expect_rd(OFF_MI_ADL, 32'h0, 32'h0);
        expect_rd(OFF_MI_DAT, 32'h0, 32'h0);
        expect_rd(OFF_PD_CTL, 32'h6403, 32'h0);
        expect_rd(OFF_PD_WRD, 32'h0, 32'h0);
        expect_rd(OFF_VS_HDR, 32'h0034_B009, 32'h0034_B009);
        expect_rd(OFF_TST0, TST0_RST, TST0_RST);
        expect_rd(OFF_TST1, TST1_RST, TST1_RST);
        expect_rd(8'h80, 32'h0, 32'h0);
        check({30'h0, downstreamRoleSelect, roleChangeEnable}, 32'h0);
        $display("test reset values done");
        cfg_write(OFF_TST0, 32'h0000_000A);
        cfg_write(OFF_TST1, 32'h1234_5678);
        expect_rd(OFF_TST1, 32'h1234_5678, 32'h1234_5678);
        check({30'h0, downstreamRoleSelect, roleChangeEnable}, 32'h3);
        stir(2, 1'b1);
        stir(2, 1'b0);
        check(downCount, 1);
        cfg_write(OFF_TST0, 32'h0000_0004);
        stir(2, 1'b1);
        stir(2, 1'b0);
        check(downCount, 1);
        check({30'h0, downstreamRoleSelect, roleChangeEnable}, 32'h0);
        $display("test link control done");
        stir(0, 1'b1);
        check({31'h0, legacyIntx}, 32'h1);
        stir(0, 1'b0);
        cfg_write(OFF_PM_CTL, 32'hFFFF_FFFF);
        expect_rd(OFF_PM_CTL, 32'h1F0B, 32'h1F0B);
        for (int i = 0; i < 4; i++)
            cfg_write(OFF_MI_HDR + 8'(4 * i), 32'hFFFF_FFFF);
        expect_rd(OFF_MI_HDR, 32'h0, 32'h00F1_6405);
        expect_rd(OFF_MI_ADL, 32'h0, 32'hFFFF_FFFC);
        expect_rd(OFF_MI_ADH, 32'h0, 32'hFFFF_FFFF);
        expect_rd(OFF_MI_DAT, 32'h0, 32'h0000_FFFF);
        stir(0, 1'b1);
        check({31'h0, legacyIntx}, 32'h0);
        stir(0, 1'b0);
        check(msgCount, 1);
        check(msgAddr[63:32], 32'hFFFF_FFFF);
        check(msgAddr[31:0], 32'hFFFF_FFFC);
        check({16'h0, msgData}, 32'h0000_FFFF);
        $display("test message interrupt done");
        cfg_write(OFF_PM_CTL, 32'h0, 4'h1);
        repeat (3) @(posedge clk_sys);
        check(hotCount, 1);
        cfg_write(OFF_PM_CTL, 32'h1, 4'h1);
        cfg_write(OFF_PM_CTL, 32'h0, 4'h1);
        repeat (3) @(posedge clk_sys);
        check(hotCount, 1);
        check({31'h0, downstream_reset_n}, 32'h1);
        stir(1, 1'b1);
        stir(1, 1'b0);
        check(eventCount, 1);
        cfg_write(OFF_PM_CTL, 32'h0);
        stir(1, 1'b1);
        stir(1, 1'b0);
        check(eventCount, 1);
        $display("test power management done");
        cfg_write(OFF_PD_WRD, 32'hCAFE_1234);
        cfg_write(OFF_PD_CTL, 32'hC014_0000);
        cfg_read(OFF_PD_CTL, u, d);
        check(u, 32'hC014_6403);
        wait_op(1'b0);
        cfg_write(OFF_PD_WRD, 32'h0);
        cfg_write(OFF_PD_CTL, 32'h0014_0000);
        cfg_read(OFF_PD_CTL, u, d);
        check(u, 32'h0014_6403);
        wait_op(1'b1);
        expect_rd(OFF_PD_WRD, 32'hCAFE_1234, 32'h0);
        $display("test product data done");
        @(posedge clk_sys);
        loadData <= '{1'b0, 1'b1, 3'h2, 1'b0, 1'b1, 5'h0A, 8'hA5};
        loadValid <= 1'b1;
        @(posedge clk_sys);
        loadValid <= 1'b0;
        expect_rd(OFF_PM_HDR, {16'h54A3, PM_NEXT_UP, PM_CAP_ID},
            {16'h54A3, PM_NEXT_DN, PM_CAP_ID});
        expect_rd(OFF_PM_CTL, 32'hA500_0000, 32'hA500_0000);
        $display("test loaded defaults done");
        stop_test();
    end
endmodule : switch_port_capability_space_tb
`default_nettype wire
